// >>> core/status_flags_pkg.sv
// status_flags_pkg: offsets, field positions and reset values for the conversion status flag block.
// assumes a 16-bit register port with 8-bit word addresses.
package status_flags_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] STATUS_WORD_ADDR = 8'h18;
  localparam logic [7:0] ERROR_ROUTE_ADDR = 8'h19;
  // result register addresses per channel (word pairs, upper word first)
  localparam logic [7:0] RESULT_CH0_ADDR = 8'h00;
  localparam logic [7:0] RESULT_CH1_ADDR = 8'h02;
  localparam logic [7:0] RESULT_CH2_ADDR = 8'h04;
  localparam logic [7:0] RESULT_CH3_ADDR = 8'h06;

  // ==========================================================
  // status word fields
  localparam int SRC_CHAN_LSB = 14;
  localparam int TIMEOUT_BIT = 11;
  localparam int AMP_HIGH_BIT = 10;
  localparam int AMP_LOW_BIT = 9;
  localparam int READY_BIT = 6;
  localparam int UNREAD_MSB = 3;

  // ==========================================================
  // error routing config fields
  localparam int TO_RESULT_BIT = 13;
  localparam int AH_RESULT_BIT = 12;
  localparam int AL_RESULT_BIT = 11;
  localparam int TO_IRQ_BIT = 5;
  localparam int READY_IRQ_BIT = 0;
  localparam logic [15:0] ERROR_ROUTE_MASK = 16'h3821;
  localparam logic [15:0] ERROR_ROUTE_RESET = 16'h0000;

  // ==========================================================
  // channel count
  localparam int NUM_CHAN = 4;

endpackage : status_flags_pkg

// >>> core/conversion_status_flags.sv
// conversion_status_flags: latched error, ready and unread-result flags plus the error routing word.
// assumes the conversion engine pulses one-cycle events with a channel number, and a register port
// that answers reads one cycle after the read strobe.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

// How it works
// [RULE_01] bits 15:14 name the channel of the latest flag or error, codes 00..11.
// [RULE_02] a reported error stays latched until status or that channel's result is read.
// [RULE_03] status bit 11 sets on an enabled watchdog timeout, channel recorded.
// [RULE_04] status bit 10 sets on an amplitude-high warning, channel recorded.
// [RULE_05] status bit 9 sets on an amplitude-low warning, channel recorded.
// [RULE_06] error flags read zero if nothing happened since the last status read.
// [RULE_07] single-channel mode: ready flag sets on every new result.
// [RULE_08] sequential mode: ready flag sets only once all active channels have new results.
// [RULE_09] bits 3..0 flag unread results for channels 0..3.
// [RULE_10] host reads the result register of a channel whose unread flag is set.
// [RULE_11] channels 2 and 3 are never reported on two-channel parts.
// [RULE_12] result read clears its unread flag; reserved status bits read zero.
// [RULE_13] flags reset to zero; status-read clear never loses a same-cycle set.
// [RULE_14] config bit 13 routes timeouts into the channel result timeout field.
// [RULE_15] config bits 12 and 11 route amplitude warnings into the result warning field.
// [RULE_16] config bit 5 lets timeouts update status and pull the interrupt low.
// [RULE_17] config bit 0 lets data ready update status and pull the interrupt low.
module conversion_status_flags (
  // clock and reset
  input wire logic refClk,
  input wire logic resetN,
  // variant and mode
  input wire logic fourChannel,
  input wire logic sequentialMode,
  input wire logic [3:0] activeChanMask,
  input wire logic irqDisable,
  // conversion engine events
  input wire logic resultValid,
  input wire logic [1:0] resultChan,
  input wire logic timeoutEvent,
  input wire logic ampHighEvent,
  input wire logic ampLowEvent,
  input wire logic [1:0] eventChan,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // result register error fields per channel
  output logic [3:0] resultTimeoutField,
  output logic [3:0] resultAmpWarnField,
  // interrupt
  output logic irqOutN
);
  import status_flags_pkg::*;

  // ==========================================================
  // decoding
  function automatic logic [3:0] chanOneHot(input logic [1:0] ch);
    chanOneHot = 4'h1 << ch;
  endfunction : chanOneHot

  function automatic logic [1:0] resultAddrChan(input logic [7:0] a);
    resultAddrChan = a[2:1];
  endfunction : resultAddrChan

  // read selection; unmapped offsets answer zero
  function automatic logic [15:0] readMux(input logic [7:0] a, input logic [15:0] st, input logic [15:0] cfg);
    case (a)
      STATUS_WORD_ADDR: readMux = st;
      ERROR_ROUTE_ADDR: readMux = cfg;
      default: readMux = 16'h0000;
    endcase
  endfunction : readMux

  // latched bit: a set beats a clear in the same cycle
  function automatic logic setClear(input logic setIn, input logic held, input logic clr);
    setClear = setIn || (held && !clr);
  endfunction : setClear

  // configuration
  logic [15:0] errCfg_q;
  logic [15:0] errCfg_d;

  // latched status
  logic [1:0] srcChan_q;
  logic [1:0] srcChan_d;
  logic timeoutFlag_q;
  logic timeoutFlag_d;
  logic ampHighFlag_q;
  logic ampHighFlag_d;
  logic ampLowFlag_q;
  logic ampLowFlag_d;
  logic readyFlag_q;
  logic readyFlag_d;

  // per-channel state, indexed by channel number
  logic [3:0] unread_q;
  logic [3:0] unread_d;
  logic [3:0] seqSeen_q;
  logic [3:0] seqSeen_d;
  logic [3:0] toField_q;
  logic [3:0] toField_d;
  logic [3:0] awField_q;
  logic [3:0] awField_d;

  // read path and interrupt
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic irqPend_q;
  logic irqPend_d;

  // ==========================================================
  // address decode
  wire logic [3:0] chanAllowed = fourChannel ? 4'hF : 4'h3; // [RULE_11]
  wire logic evChanOk = chanAllowed[eventChan]; // [RULE_11]
  wire logic resChanOk = chanAllowed[resultChan]; // [RULE_11]
  wire logic statusRead = regRead && (regAddr == STATUS_WORD_ADDR);
  wire logic cfgWrite = regWrite && (regAddr == ERROR_ROUTE_ADDR);
  wire logic isResultAddr = (regAddr[7:3] == 5'h00);
  wire logic resultRead = regRead && isResultAddr && chanAllowed[resultAddrChan(regAddr)];
  wire logic [3:0] resultReadHot = resultRead ? chanOneHot(resultAddrChan(regAddr)) : 4'h0;
  // a read of the named channel's result also releases the latched errors
  wire logic srcResultRead = resultRead && (resultAddrChan(regAddr) == srcChan_q); // [RULE_02]
  wire logic errClear = statusRead || srcResultRead; // [RULE_02] [RULE_06]

  // ==========================================================
  // event qualification
  // timeouts need their routing bit before they reach status or the pin
  wire logic toSet = timeoutEvent && evChanOk && errCfg_q[TO_IRQ_BIT]; // [RULE_03] [RULE_16]
  wire logic ahSet = ampHighEvent && evChanOk; // [RULE_04]
  wire logic alSet = ampLowEvent && evChanOk; // [RULE_05]
  wire logic anyErrSet = toSet || ahSet || alSet;
  // ==========================================================
  // ready tracking
  wire logic newResult = resultValid && resChanOk;
  wire logic [3:0] resultHot = newResult ? chanOneHot(resultChan) : 4'h0;
  wire logic [3:0] activeOk = activeChanMask & chanAllowed;
  wire logic [3:0] seqNext = seqSeen_q | resultHot;
  wire logic seqDone = newResult && ((seqNext & activeOk) == activeOk); // [RULE_08]
  wire logic readyEvent = sequentialMode ? seqDone : newResult; // [RULE_07] [RULE_08]
  wire logic readySet = readyEvent && errCfg_q[READY_IRQ_BIT]; // [RULE_17]

  // ==========================================================
  // status word and read path
  // captured before any clear takes effect; reserved bits stay zero
  wire logic [15:0] statusWord = {
    srcChan_q, // [RULE_01]
    2'b00, // [RULE_12]
    timeoutFlag_q,
    ampHighFlag_q,
    ampLowFlag_q,
    2'b00, // [RULE_12]
    readyFlag_q,
    2'b00, // [RULE_12]
    unread_q[0],
    unread_q[1],
    unread_q[2],
    unread_q[3] // [RULE_09] channel 0 sits in the highest unread bit
  };

  wire logic [15:0] rdataNext = readMux(regAddr, statusWord, errCfg_q);

  // ==========================================================
  // next state; a set in the clearing cycle always wins, so a read never swallows a fresh event
  assign errCfg_d = cfgWrite ? (regWdata & ERROR_ROUTE_MASK) : errCfg_q;
  // latest event overwrites the channel: simultaneous faults on two channels report only one
  assign srcChan_d = anyErrSet ? eventChan : srcChan_q; // [RULE_01]
  assign timeoutFlag_d = setClear(toSet, timeoutFlag_q, errClear); // [RULE_03] [RULE_13]
  assign ampHighFlag_d = setClear(ahSet, ampHighFlag_q, errClear); // [RULE_04] [RULE_13]
  assign ampLowFlag_d = setClear(alSet, ampLowFlag_q, errClear); // [RULE_05] [RULE_13]
  assign readyFlag_d = setClear(readySet, readyFlag_q, statusRead); // [RULE_07] [RULE_13]
  assign irqPend_d = setClear(toSet || readySet, irqPend_q, errClear); // [RULE_16] [RULE_17]
  assign rdata_d = regRead ? rdataNext : 16'h0000;

  // per-channel routing of events into the result register fields
  wire logic [3:0] evHot = evChanOk ? chanOneHot(eventChan) : 4'h0;
  wire logic toRoute = timeoutEvent && errCfg_q[TO_RESULT_BIT]; // [RULE_14]
  wire logic awRoute = (ampHighEvent && errCfg_q[AH_RESULT_BIT]) ||
                       (ampLowEvent && errCfg_q[AL_RESULT_BIT]); // [RULE_15]
  wire logic seqClear = !sequentialMode || seqDone; // [RULE_08]

  // ==========================================================
  // scalar registers
  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      errCfg_q <= ERROR_ROUTE_RESET;
    end else begin
      errCfg_q <= errCfg_d;
    end
  end

  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      srcChan_q <= 2'b00; // [RULE_13]
    end else begin
      srcChan_q <= srcChan_d;
    end
  end

  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      timeoutFlag_q <= 1'b0;
    end else begin
      timeoutFlag_q <= timeoutFlag_d;
    end
  end

  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      ampHighFlag_q <= 1'b0;
    end else begin
      ampHighFlag_q <= ampHighFlag_d;
    end
  end

  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      ampLowFlag_q <= 1'b0;
    end else begin
      ampLowFlag_q <= ampLowFlag_d;
    end
  end

  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      readyFlag_q <= 1'b0;
    end else begin
      readyFlag_q <= readyFlag_d;
    end
  end

  // read data is zero outside its one-cycle slot, so several slaves can be or-ed together
  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // interrupt level stays until the status or source result read releases it
  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      irqPend_q <= 1'b0;
    end else begin
      irqPend_q <= irqPend_d;
    end
  end

  // ==========================================================
  // per-channel state; each slice owns one bit of every per-channel vector
  // unread and routed-error bits clear together on that channel's result read
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    wire logic clrHere = resultReadHot[ch];
    wire logic setHere = resultHot[ch];
    assign unread_d[ch] = setClear(setHere, unread_q[ch], clrHere); // [RULE_09] [RULE_12]
    assign seqSeen_d[ch] = seqClear ? 1'b0 : seqNext[ch]; // [RULE_08]
    assign toField_d[ch] = setClear(toRoute && evHot[ch], toField_q[ch], clrHere); // [RULE_14]
    assign awField_d[ch] = setClear(awRoute && evHot[ch], awField_q[ch], clrHere); // [RULE_15]

    always_ff @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
        unread_q[ch] <= 1'b0;
      end else begin
        unread_q[ch] <= unread_d[ch];
      end
    end

    // sequence tracking restarts whenever a full set completes or the mode drops
    always_ff @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
        seqSeen_q[ch] <= 1'b0;
      end else begin
        seqSeen_q[ch] <= seqSeen_d[ch];
      end
    end

    always_ff @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
        toField_q[ch] <= 1'b0;
      end else begin
        toField_q[ch] <= toField_d[ch];
      end
    end

    always_ff @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
        awField_q[ch] <= 1'b0;
      end else begin
        awField_q[ch] <= awField_d[ch];
      end
    end
  end

  // ==========================================================
  // outputs
  assign regRdata = rdata_q;
  assign resultTimeoutField = toField_q;
  assign resultAmpWarnField = awField_q;
  // interrupt is a level from a register, masked by irqDisable, held low until the status or source result read
  assign irqOutN = !(irqPend_q && !irqDisable); // [RULE_16] [RULE_17]

endmodule : conversion_status_flags

// >>> tb/conversion_status_flags_sva.sv
// checker: port relations of the status flag block
// assumes bind onto conversion_status_flags, one clock
`timescale 1ns/100ps
module conversion_status_flags_sva import status_flags_pkg::*; (
  input wire logic refClk, resetN, fourChannel, irqDisable, regWrite, regRead, irqOutN,
  input wire logic resultValid, timeoutEvent, ampHighEvent, ampLowEvent,
  input wire logic [1:0] resultChan, eventChan,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata, regRdata,
  input wire logic [3:0] resultTimeoutField
);
  // ==========================================================
  // routing word is not on a port, so it is mirrored here
  logic [15:0] cfgQ;
  always_ff @(posedge refClk or negedge resetN) begin
    if (!resetN) cfgQ <= 16'h0000;
    else if (regWrite && regAddr == ERROR_ROUTE_ADDR) cfgQ <= regWdata;
  end
  wire rdS = regRead && regAddr == STATUS_WORD_ADDR;
  wire anyEv = timeoutEvent || ampHighEvent || ampLowEvent;
  wire evOk = fourChannel || !eventChan[1];
  default clocking @(posedge refClk); endclocking
  default disable iff (!resetN);
  chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data outside read slot");
  chk_resv_zero: assert property ($past(rdS) |-> (regRdata & 16'h31b0) == 16'h0000)
    else $error("reserved status bits set");
  chk_to_irq: assert property (timeoutEvent && evOk && cfgQ[TO_IRQ_BIT] && !irqDisable |=> !irqOutN)
    else $error("timeout did not pull irq");
  chk_irq_off: assert property (irqDisable |-> irqOutN)
    else $error("irq low while disabled");
  chk_flag_clear: assert property ((rdS && !anyEv) ##1 !anyEv ##1 rdS |=> regRdata[11:9] == 3'b000)
    else $error("error flags survived status read");
  chk_amp_high: assert property (ampHighEvent && evOk ##1 rdS |=> regRdata[AMP_HIGH_BIT]
    && regRdata[15:14] == $past(eventChan, 2)) else $error("amp high flag or channel wrong");
  chk_to_chan: assert property (timeoutEvent && evOk && cfgQ[TO_IRQ_BIT] ##1 rdS |=> regRdata[TIMEOUT_BIT]
    && regRdata[15:14] == $past(eventChan, 2)) else $error("timeout flag or channel wrong");
  chk_unread_set: assert property (resultValid && (fourChannel || !resultChan[1]) ##1 rdS
    |=> regRdata[3 - $past(resultChan, 2)]) else $error("unread flag missing");
  chk_two_chan: assert property (!fourChannel && $past(rdS) |-> regRdata[1:0] == 2'b00 && !regRdata[15])
    else $error("upper channel reported on two-channel part");
  chk_to_field: assert property (timeoutEvent && evOk && cfgQ[TO_RESULT_BIT]
    |=> resultTimeoutField[$past(eventChan)]) else $error("timeout not routed to result");
  cover property (rdS);
  cover property ($fell(irqOutN));
  cover property (resultValid ##1 rdS);
endmodule : conversion_status_flags_sva
bind conversion_status_flags conversion_status_flags_sva chk_u (.*);

// >>> tb/host_model.sv
// host_model: register port master standing in for the host
// assumes the block answers a read one cycle after the strobe
`timescale 1ns/100ps
module host_model (
  input wire logic refClk,
  output logic [7:0] regAddr,
  output logic [15:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [15:0] regRdata
);
  initial {regAddr, regWdata, regWrite, regRead} = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] dIn);
    @(posedge refClk);
    {regAddr, regWdata, regWrite} <= {a, dIn, 1'b1};
    @(posedge refClk);
    regWrite <= 1'b0;
  endtask : wr
  // pending results are fetched by reading that channel's result word
  task automatic rd(input logic [7:0] a, output logic [15:0] dOut);
    @(posedge refClk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge refClk);
    regRead <= 1'b0;
    @(posedge refClk);
    dOut = regRdata;
  endtask : rd
endmodule : host_model

// >>> tb/tb_conversion_status_flags.sv
// tb_conversion_status_flags: directed scenarios for the status flag block
// assumes host_model drives the register port
`timescale 1ns/100ps
module tb_conversion_status_flags;
  import status_flags_pkg::*;
  logic refClk, resetN, fourChannel, sequentialMode, irqDisable, regWrite, regRead, irqOutN;
  logic resultValid, timeoutEvent, ampHighEvent, ampLowEvent;
  logic [3:0] activeChanMask, toF, awF;
  logic [1:0] resultChan, eventChan;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata, d;
  int nMismatch = 0;
  int nTests = 0;
  conversion_status_flags dut_u (.refClk(refClk), .resetN(resetN), .fourChannel(fourChannel),
    .sequentialMode(sequentialMode), .activeChanMask(activeChanMask), .irqDisable(irqDisable),
    .resultValid(resultValid), .resultChan(resultChan), .timeoutEvent(timeoutEvent), .ampHighEvent(ampHighEvent),
    .ampLowEvent(ampLowEvent), .eventChan(eventChan), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .resultTimeoutField(toF), .resultAmpWarnField(awF), .irqOutN(irqOutN));
  host_model host_u (.refClk(refClk), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata));
  initial begin
    refClk = 1'b0;
    forever #10 refClk = ~refClk;
  end
  // ==========================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // kind bits: result, timeout, amp high, amp low
  task automatic ev(input logic [3:0] k, input logic [1:0] ch);
    @(posedge refClk);
    {resultValid, timeoutEvent, ampHighEvent, ampLowEvent, resultChan, eventChan} <= {k, ch, ch};
    @(posedge refClk);
    {resultValid, timeoutEvent, ampHighEvent, ampLowEvent} <= 4'h0;
    @(negedge refClk);
  endtask : ev
  task automatic testDone;
    if (nMismatch == 0 && nTests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : testDone
  initial begin
    {resetN, fourChannel, sequentialMode, irqDisable, activeChanMask} = '0;
    {resultValid, timeoutEvent, ampHighEvent, ampLowEvent, resultChan, eventChan} = '0;
    repeat (12) @(posedge refClk);
    resetN <= 1'b1;
    host_u.rd(STATUS_WORD_ADDR, d); chk(d, 16'h0000);
    host_u.rd(ERROR_ROUTE_ADDR, d); chk(d, 16'h0000);
    // two-channel part first, so no upper-channel state lingers later
    ev(4'b0010, 2'd2); ev(4'b1000, 2'd3);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d, 16'h0000);
    fourChannel <= 1'b1;
    host_u.wr(ERROR_ROUTE_ADDR, 16'hffff);
    host_u.rd(ERROR_ROUTE_ADDR, d); chk(d, ERROR_ROUTE_MASK);
    ev(4'b0100, 2'd1); chk({15'h0000, irqOutN}, 16'h0000);
    chk({12'h000, toF}, 16'h0002);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d, 16'h4800);
    ev(4'b0001, 2'd2);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d, 16'h8200);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d & 16'h0e00, 16'h0000);
    ev(4'b0010, 2'd3); chk({12'h000, awF}, 16'h000c);
    host_u.rd(RESULT_CH3_ADDR, d);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d & 16'h0e00, 16'h0000);
    ev(4'b1000, 2'd0); chk({15'h0000, irqOutN}, 16'h0000);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d & 16'h3fff, 16'h0048);
    host_u.rd(RESULT_CH0_ADDR, d);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d & 16'h3fff, 16'h0000);
    {sequentialMode, activeChanMask} <= {1'b1, 4'b0011};
    ev(4'b1000, 2'd0);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d & 16'h3fff, 16'h0008);
    ev(4'b1000, 2'd1);
    host_u.rd(STATUS_WORD_ADDR, d); chk(d & 16'h3fff, 16'h004c);
    irqDisable <= 1'b1;
    ev(4'b1000, 2'd0); chk({15'h0000, irqOutN}, 16'h0001);
    testDone();
  end
  initial begin
    #200000;
    nMismatch++;
    testDone();
  end
endmodule : tb_conversion_status_flags
